//--- logic/spb_pkg.sv
// types shared by the spin probe block
package spb_pkg;
    // probe sequence states
    typedef enum logic [2:0] {
        SPB_IDLE,
        SPB_SENSE,
        SPB_FLOAT,
        SPB_BRAKE,
        SPB_REJOIN,
        SPB_DONE
    } spb_state_e;
    // measurements from the analog front end
    typedef struct packed {
        logic [15:0] emfMv;     // back-emf amplitude in mV
        logic [15:0] currentMa; // phase current in mA
        logic [6:0] speedPct;   // forward speed in % of max
        logic forward;          // rotor spins forward
    } spb_meas_s;
    // gate commands to the three half bridges
    typedef struct packed {
        logic [2:0] highOn;
        logic [2:0] lowOn;
    } spb_gate_s;
endpackage

//--- logic/spb_probe.sv
// start-up rotor probe with brake, float and resync, configured over apb
`timescale 1ns/1ps
`include "spb_regs.svh"
// Behaviour
// - resync code 0-9 gives 5-50 percent
// - brake side bit selects high or low
// - exit bit 0 leaves after brake time
// - exit bit 1 also needs current threshold
// - brake current code 0-5 maps to mA threshold
// - standstill emf code selects mV threshold
// - config word read/write, resets to zero
// - probe runs only when enabled
// - probe brakes only when brake enabled
// - resync only when rejoin enabled
module spb_probe #(
    parameter int CYC_PER_MS = `SPB_CLK_MHZ * `SPB_US_PER_MS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // motor side
    input wire logic startReq,
    input wire spb_pkg::spb_meas_s meas,
    output spb_pkg::spb_gate_s gates,
    output logic closedLoopGo,
    output logic stopHandling,
    output logic probeDone
);
    logic [31:0] cfg_reg;              // configuration word
    spb_pkg::spb_state_e state_reg;    // probe sequence state
    spb_pkg::spb_state_e state_next;
    spb_pkg::spb_meas_s measS1_reg;    // first sync stage
    spb_pkg::spb_meas_s measS2_reg;    // second sync stage
    logic startS1_reg;
    logic startS2_reg;
    logic startOld_reg;
    logic timerStart;                  // restart hold timer
    logic [13:0] timerMs;              // hold time to load
    logic timerDone;
    logic [31:0] prdata_next;
    logic badAddr;
    // config field views
    logic [3:0] resyncCode;
    logic [2:0] ilimCode;
    logic [2:0] emfCode;
    logic [6:0] minSpeedPct;
    logic [15:0] brakeLimitMa;
    logic [15:0] emfLimitMv;
    logic stationary;
    logic speedOk;
    logic brakeExit;
    logic startRise;

    // decode hold duration code to ms, shared by brake and float
    function automatic logic [13:0] holdMs(input logic [3:0] code);
        logic [13:0] ms;
        ms = 14'h0000;
        unique case (code)
            4'h0: ms = 14'h000A;
            4'h1: ms = 14'h0032;
            4'h2: ms = 14'h0064;
            4'h3: ms = 14'h00C8;
            4'h4: ms = 14'h012C;
            4'h5: ms = 14'h0190;
            4'h6: ms = 14'h01F4;
            4'h7: ms = 14'h02EE;
            4'h8: ms = 14'h03E8;
            4'h9: ms = 14'h07D0;
            4'hA: ms = 14'h0BB8;
            4'hB: ms = 14'h0FA0;
            4'hC: ms = 14'h1388;
            4'hD: ms = 14'h1D4C;
            4'hE: ms = 14'h2710;
            4'hF: ms = 14'h3A98;
        endcase
        return ms;
    endfunction
    // field slices of the config word
    assign resyncCode = cfg_reg[`SPB_RESYNC_HI:`SPB_RESYNC_LO];
    assign ilimCode = cfg_reg[`SPB_ILIM_HI:`SPB_ILIM_LO];
    assign emfCode = cfg_reg[`SPB_EMF_HI:`SPB_EMF_LO];
    // resync speed decode, invalid codes clamp to top step
    assign minSpeedPct = (resyncCode > `SPB_RESYNC_MAX) ? 7'h32
        : 7'(({3'h0, resyncCode} + 7'h01) * 7'h05);
    always_comb
    begin
        unique case (ilimCode)
            3'h0: brakeLimitMa = 16'h003E;
            3'h1: brakeLimitMa = 16'h007D;
            3'h2: brakeLimitMa = 16'h00BB;
            3'h3: brakeLimitMa = 16'h0138;
            3'h4: brakeLimitMa = 16'h0271;
            default: brakeLimitMa = 16'h04E2; // codes 6,7 not valid
        endcase
    end
    always_comb
    begin
        unique case (emfCode)
            3'h0: emfLimitMv = 16'h0032;
            3'h1: emfLimitMv = 16'h004B;
            3'h2: emfLimitMv = 16'h0064;
            3'h3: emfLimitMv = 16'h00FA;
            3'h4: emfLimitMv = 16'h01F4;
            3'h5: emfLimitMv = 16'h02EE;
            3'h6: emfLimitMv = 16'h03E8;
            3'h7: emfLimitMv = 16'h05DC;
        endcase
    end
    // motor judgements from synced measurements
    assign stationary = measS2_reg.emfMv < emfLimitMv;
    assign speedOk = measS2_reg.forward && (measS2_reg.speedPct >= minSpeedPct);
    // exit by time alone; exit needs current too
    assign brakeExit = timerDone &&
        (!cfg_reg[`SPB_BIT_EXIT] || (measS2_reg.currentMa < brakeLimitMa));
    assign startRise = startS2_reg && !startOld_reg;

    // two-stage sync of pin-level inputs
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            measS1_reg <= '0;
            measS2_reg <= '0;
            startS1_reg <= 1'b0;
            startS2_reg <= 1'b0;
            startOld_reg <= 1'b0;
        end
        else
        begin
            measS1_reg <= meas;
            measS2_reg <= measS1_reg;
            startS1_reg <= startReq;
            startS2_reg <= startS1_reg;
            startOld_reg <= startS2_reg;
        end
    end

    // apb decode, zero wait states
    assign pready = 1'b1;
    assign badAddr = (paddr != `SPB_CFG_ADDR) && (paddr != `SPB_STAT_ADDR)
        && (paddr != `SPB_MEAS_ADDR);
    assign pslverr = psel && penable && badAddr;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfg_reg <= `SPB_CFG_RESET;
        else if (psel && penable && pwrite && (paddr == `SPB_CFG_ADDR))
            cfg_reg <= pwdata & `SPB_CFG_WMASK;
    end

    // read mux
    always_comb
    begin
        prdata_next = 32'h00000000;
        if (paddr == `SPB_CFG_ADDR)
            prdata_next = cfg_reg;
        else if (paddr == `SPB_STAT_ADDR)
            prdata_next = {25'h0000000, speedOk, stationary, timerDone, 1'b0, state_reg};
        else if (paddr == `SPB_MEAS_ADDR)
            prdata_next = {9'h000, minSpeedPct, brakeLimitMa};
    end

    // registered read data, loaded in setup phase
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= prdata_next;
    end

    // hold timer
    spb_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(timerStart),
        .loadMs(timerMs),
        .expired(timerDone)
    );

    // sequence next state and timer loads
    always_comb
    begin
        state_next = state_reg;
        timerStart = 1'b0;
        timerMs = holdMs(cfg_reg[`SPB_BRKT_HI:`SPB_BRKT_LO]);
        unique case (state_reg)
            spb_pkg::SPB_IDLE:
            begin
                if (startRise)
                begin
                    if (cfg_reg[`SPB_BIT_PROBE_EN])
                        state_next = spb_pkg::SPB_SENSE;
                    else
                        state_next = spb_pkg::SPB_DONE;
                end
            end
            spb_pkg::SPB_SENSE:
            begin
                if (stationary)
                    state_next = spb_pkg::SPB_DONE;
                else if (cfg_reg[`SPB_BIT_REJOIN_EN] && speedOk)
                    state_next = spb_pkg::SPB_REJOIN;
                else if (cfg_reg[`SPB_BIT_FLOAT_EN])
                begin
                    state_next = spb_pkg::SPB_FLOAT;
                    timerStart = 1'b1;
                    timerMs = holdMs(cfg_reg[`SPB_FLTT_HI:`SPB_FLTT_LO]);
                end
                else if (cfg_reg[`SPB_BIT_BRAKE_EN])
                begin
                    state_next = spb_pkg::SPB_BRAKE;
                    timerStart = 1'b1;
                end
                else
                    state_next = spb_pkg::SPB_DONE;
            end
            spb_pkg::SPB_FLOAT:
            begin
                if (timerDone)
                begin
                    if (cfg_reg[`SPB_BIT_BRAKE_EN])
                    begin
                        state_next = spb_pkg::SPB_BRAKE;
                        timerStart = 1'b1;
                    end
                    else
                        state_next = spb_pkg::SPB_DONE;
                end
            end
            spb_pkg::SPB_BRAKE:
            begin
                // time exit; current and time exit
                if (brakeExit)
                    state_next = spb_pkg::SPB_DONE;
            end
            spb_pkg::SPB_REJOIN:
                state_next = spb_pkg::SPB_IDLE;
            spb_pkg::SPB_DONE:
                state_next = spb_pkg::SPB_IDLE;
            default: state_next = spb_pkg::SPB_IDLE; // unused codes recover
        endcase
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_reg <= spb_pkg::SPB_IDLE;
        else
            state_reg <= state_next;
    end

    // registered outputs to bridges and loop
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            gates <= '0;
            closedLoopGo <= 1'b0;
            stopHandling <= 1'b0;
            probeDone <= 1'b0;
        end
        else
        begin
            gates.highOn <= (state_next == spb_pkg::SPB_BRAKE && !cfg_reg[`SPB_BIT_SIDE])
                ? 3'h7 : 3'h0;
            gates.lowOn <= (state_next == spb_pkg::SPB_BRAKE && cfg_reg[`SPB_BIT_SIDE])
                ? 3'h7 : 3'h0;
            closedLoopGo <= state_next == spb_pkg::SPB_REJOIN;
            stopHandling <= state_next == spb_pkg::SPB_DONE;
            probeDone <= (state_next == spb_pkg::SPB_DONE)
                || (state_next == spb_pkg::SPB_REJOIN);
        end
    end

    // checks
    a_side_high_brake: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == spb_pkg::SPB_BRAKE && !$past(cfg_reg[`SPB_BIT_SIDE]))
        |-> gates.highOn == 3'h7 && gates.lowOn == 3'h0)
        else $error("high side brake wrong");
    a_side_low_brake: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == spb_pkg::SPB_BRAKE && $past(cfg_reg[`SPB_BIT_SIDE]))
        |-> gates.lowOn == 3'h7 && gates.highOn == 3'h0)
        else $error("low side brake wrong");
    a_exit_time_only: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == spb_pkg::SPB_BRAKE && timerDone && !cfg_reg[`SPB_BIT_EXIT]
        |=> state_reg == spb_pkg::SPB_DONE)
        else $error("brake did not end on time");
    a_exit_current_hold: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == spb_pkg::SPB_BRAKE && cfg_reg[`SPB_BIT_EXIT]
        && measS2_reg.currentMa >= brakeLimitMa |=> state_reg == spb_pkg::SPB_BRAKE)
        else $error("brake left above current limit");
    a_cfg_reset_zero: assert property (@(posedge core_clk)
        $past(rst) |-> cfg_reg == 32'h00000000)
        else $error("config not cleared by reset");
    a_probe_gate: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == spb_pkg::SPB_IDLE && !cfg_reg[`SPB_BIT_PROBE_EN]
        |=> state_reg != spb_pkg::SPB_SENSE)
        else $error("probe ran while disabled");
    a_brake_gate: assert property (@(posedge core_clk) disable iff (rst)
        state_reg != spb_pkg::SPB_BRAKE && !cfg_reg[`SPB_BIT_BRAKE_EN]
        |=> state_reg != spb_pkg::SPB_BRAKE)
        else $error("brake while disabled");
    a_rejoin_gate: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == spb_pkg::SPB_REJOIN |-> $past(cfg_reg[`SPB_BIT_REJOIN_EN]))
        else $error("resync while disabled");
    a_rejoin_speed: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == spb_pkg::SPB_REJOIN |-> $past(speedOk) && closedLoopGo)
        else $error("resync below min speed");
    a_resync_decode: assert property (@(posedge core_clk) disable iff (rst)
        resyncCode <= `SPB_RESYNC_MAX |-> minSpeedPct == 7'(resyncCode * 5 + 5))
        else $error("resync speed decode wrong");
    c_brake_seen: cover property (@(posedge core_clk) state_reg == spb_pkg::SPB_BRAKE);
    c_rejoin_seen: cover property (@(posedge core_clk) closedLoopGo);
    c_float_brake: cover property (@(posedge core_clk)
        state_reg == spb_pkg::SPB_FLOAT ##1 state_reg == spb_pkg::SPB_BRAKE);
endmodule // spb_probe

//--- logic/spb_regs.svh
// register offsets, field positions and timing constants of the spin probe block
`ifndef SPB_REGS_SVH
`define SPB_REGS_SVH
`define SPB_CFG_ADDR 12'h080
`define SPB_STAT_ADDR 12'h084
`define SPB_MEAS_ADDR 12'h088
`define SPB_CFG_RESET 32'h00000000
`define SPB_CFG_WMASK 32'hFFFFFFFF
`define SPB_BIT_PROBE_EN 30
`define SPB_BIT_BRAKE_EN 29
`define SPB_BIT_FLOAT_EN 28
`define SPB_BIT_REJOIN_EN 26
`define SPB_RESYNC_HI 25
`define SPB_RESYNC_LO 22
`define SPB_BIT_SIDE 21
`define SPB_BIT_EXIT 20
`define SPB_ILIM_HI 19
`define SPB_ILIM_LO 17
`define SPB_BRKT_HI 16
`define SPB_BRKT_LO 13
`define SPB_FLTT_HI 12
`define SPB_FLTT_LO 9
`define SPB_EMF_HI 8
`define SPB_EMF_LO 6
`define SPB_RESYNC_MAX 4'h9
`define SPB_ILIM_MAX 3'h5
`define SPB_CLK_MHZ 200
`define SPB_US_PER_MS 1000
`endif

//--- logic/spb_timer.sv
// millisecond down counter used for brake and float hold times
`timescale 1ns/1ps
`include "spb_regs.svh"
module spb_timer #(
    parameter int CYC_PER_MS = `SPB_CLK_MHZ * `SPB_US_PER_MS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic [13:0] loadMs,
    // status
    output logic expired
);
    logic [31:0] tickCnt_reg; // cycles inside current ms
    logic [13:0] msLeft_reg;  // whole ms still to run
    logic running_reg;        // timer active
    // prescaler and ms countdown
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tickCnt_reg <= 32'h00000000;
            msLeft_reg <= 14'h0000;
            running_reg <= 1'b0;
        end
        else if (start)
        begin
            tickCnt_reg <= 32'h00000000;
            msLeft_reg <= loadMs;
            running_reg <= 1'b1;
        end
        else if (running_reg)
        begin
            // one ms elapsed
            if (tickCnt_reg == 32'(CYC_PER_MS - 1))
            begin
                tickCnt_reg <= 32'h00000000;
                msLeft_reg <= msLeft_reg - 14'h0001;
                if (msLeft_reg == 14'h0001)
                    running_reg <= 1'b0;
            end
            else
                tickCnt_reg <= tickCnt_reg + 32'h00000001;
        end
    end
    // expiry flag, high whenever no count runs; kept off start so that
    // the sequencer, which raises start on expiry, has no comb loop
    assign expired = !running_reg;
endmodule // spb_timer

//--- testbench/spb_motor_model.sv
// behavioural three-phase motor seen through the half bridges
`timescale 1ns/1ps
module spb_motor_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench settings, copied while load is high
    input wire logic [15:0] emfSet,
    input wire logic [15:0] ampSet,
    input wire logic [6:0] speedSet,
    input wire logic load,
    // bridge side
    input wire spb_pkg::spb_gate_s gates,
    output spb_pkg::spb_meas_s meas
);
    // shorted windings bleed current by 10 mA a cycle while braking
    always_ff @(posedge core_clk)
    begin
        if (rst || load)
        begin
            meas <= {emfSet, ampSet, speedSet, 1'b1};
        end
        else if (gates != 6'h00)
        begin
            meas.currentMa <= (meas.currentMa > 16'h000A) ? meas.currentMa - 16'h000A : 16'h0000;
        end
    end
endmodule // spb_motor_model

//--- testbench/tb.sv
// self-checking bench for the spin probe block
`timescale 1ns/1ps
`include "spb_regs.svh"
module tb;
    // clock, reset and apb
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // motor side
    logic startReq = 1'b0;
    logic load = 1'b1;
    logic closedLoopGo;
    logic stopHandling;
    logic probeDone;
    logic [15:0] emfSet = 16'h0000;
    logic [15:0] ampSet = 16'h07D0;
    logic [6:0] speedSet = 7'h00;
    spb_pkg::spb_meas_s meas;
    spb_pkg::spb_gate_s gates;
    // bookkeeping
    int num_errors = 0;
    int tests_run = 0;
    int brakeCyc;
    int runCyc;
    logic [31:0] rd;
    logic err;
    logic sawGo;
    logic sawStop;
    logic sawDone;
    logic [5:0] brakeGates;
    // decoded thresholds in mV and mA
    logic [15:0] emfTab [8] = '{16'h0032, 16'h004B, 16'h0064, 16'h00FA,
        16'h01F4, 16'h02EE, 16'h03E8, 16'h05DC};
    logic [15:0] ampTab [8] = '{16'h003E, 16'h007D, 16'h00BB, 16'h0138,
        16'h0271, 16'h04E2, 16'h04E2, 16'h04E2};

    // clock of 5 ns
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    // block under test, 10 cycles a millisecond
    spb_probe #(.CYC_PER_MS(10)) uut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .startReq(startReq),
        .meas(meas), .gates(gates), .closedLoopGo(closedLoopGo),
        .stopHandling(stopHandling), .probeDone(probeDone));

    // motor partner
    spb_motor_model motor (.core_clk(core_clk), .rst(rst), .emfSet(emfSet),
        .ampSet(ampSet), .speedSet(speedSet), .load(load), .gates(gates), .meas(meas));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            chk(32'h0, 32'h1, "apb hang");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // config word: flags are probe, brake, rejoin, side, exit
    function automatic logic [31:0] mk(input logic [4:0] f, input logic [3:0] rs,
        input logic [2:0] il, input logic [3:0] bt, input logic [2:0] em);
        mk = 32'h00000000;
        mk[`SPB_BIT_PROBE_EN] = f[4];
        mk[`SPB_BIT_BRAKE_EN] = f[3];
        mk[`SPB_BIT_REJOIN_EN] = f[2];
        mk[`SPB_BIT_SIDE] = f[1];
        mk[`SPB_BIT_EXIT] = f[0];
        mk[`SPB_RESYNC_HI:`SPB_RESYNC_LO] = rs;
        mk[`SPB_ILIM_HI:`SPB_ILIM_LO] = il;
        mk[`SPB_BRKT_HI:`SPB_BRKT_LO] = bt;
        mk[`SPB_EMF_HI:`SPB_EMF_LO] = em;
    endfunction

    // one probe run, watching pulses and brake gates
    task automatic run(input logic [31:0] cfg, input logic [15:0] emf, input logic [6:0] spd);
        apb(1'b1, `SPB_CFG_ADDR, cfg);
        emfSet <= emf;
        speedSet <= spd;
        repeat (4) @(posedge core_clk);
        load <= 1'b0;
        startReq <= 1'b1;
        {sawGo, sawStop, sawDone, brakeGates} = 9'h000;
        brakeCyc = 0;
        runCyc = 0;
        for (int n = 0; n < 1500 && sawDone !== 1'b1; n++)
        begin
            @(posedge core_clk);
            runCyc++;
            if (gates !== 6'h00)
            begin
                brakeCyc++;
                brakeGates = gates;
            end
            sawGo = sawGo | (closedLoopGo === 1'b1);
            sawStop = sawStop | (stopHandling === 1'b1);
            sawDone = (probeDone === 1'b1);
        end
        startReq <= 1'b0;
        load <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    // verdict, reached once
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog well past the expected run
    initial
    begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end

    // test sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, `SPB_CFG_ADDR, 32'h00000000);
        chk(rd, 32'h00000000, "cfg reset");
        apb(1'b0, `SPB_STAT_ADDR, 32'h00000000);
        chk(rd, 32'h00000030, "status idle");
        apb(1'b1, `SPB_CFG_ADDR, 32'hA5A55A5A);
        apb(1'b0, `SPB_CFG_ADDR, 32'h00000000);
        chk(rd, 32'hA5A55A5A, "cfg readback");
        apb(1'b0, 12'h0FC, 32'h00000000);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h00000000, "unmapped read zero");
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, `SPB_CFG_ADDR, mk(5'h00, 4'(i), 3'(i), 4'h0, 3'h0));
            apb(1'b0, `SPB_MEAS_ADDR, 32'h00000000);
            chk(rd, {9'h000, (i < 10) ? 7'(5 * (i + 1)) : 7'h32, ampTab[i % 8]}, "decode");
        end
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            run(mk(5'h14, 4'h0, 3'h0, 4'h0, 3'(i)), emfTab[i] - 16'h0001, 7'h64);
            chk({sawStop, sawGo}, 2'b10, "standstill");
            run(mk(5'h14, 4'h0, 3'h0, 4'h0, 3'(i)), emfTab[i] + 16'h0001, 7'h64);
            chk({sawStop, sawGo}, 2'b01, "spinning");
        end
        run(mk(5'h14, 4'h3, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h14);
        chk({sawStop, sawGo}, 2'b01, "speed at limit");
        run(mk(5'h14, 4'h3, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h13);
        chk({sawStop, sawGo}, 2'b10, "speed below limit");
        run(mk(5'h10, 4'h0, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h64);
        chk({sawStop, sawGo}, 2'b10, "rejoin off");
        $display("sense test done");
        run(mk(5'h1C, 4'h9, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h05);
        chk(brakeGates, 6'h38, "high side brake");
        chk(brakeCyc >= 95 && brakeCyc <= 110, 1, "brake 10 ms");
        run(mk(5'h1E, 4'h9, 3'h0, 4'h1, 3'h0), 16'h03E8, 7'h05);
        chk(brakeGates, 6'h07, "low side brake");
        chk(brakeCyc >= 495 && brakeCyc <= 510, 1, "brake 50 ms");
        run(mk(5'h1D, 4'h9, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h05);
        chk(brakeCyc >= 185 && brakeCyc <= 215, 1, "brake waits current");
        run(mk(5'h1D, 4'h9, 3'h0, 4'h1, 3'h0), 16'h03E8, 7'h05);
        chk(brakeCyc >= 495 && brakeCyc <= 510, 1, "brake waits time");
        run(mk(5'h1C, 4'h9, 3'h0, 4'h0, 3'h0) | (32'h00000001 << `SPB_BIT_FLOAT_EN)
            | (32'h00000001 << `SPB_FLTT_LO), 16'h03E8, 7'h05);
        chk(runCyc >= 600 && runCyc <= 615, 1, "float 50 ms");
        chk(brakeCyc >= 95 && brakeCyc <= 110, 1, "brake after float");
        chk(brakeGates, 6'h38, "float then high side");
        run(mk(5'h14, 4'h9, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h05);
        chk({sawStop, brakeCyc == 0}, 2'b11, "brake off");
        run(mk(5'h04, 4'h0, 3'h0, 4'h0, 3'h0), 16'h03E8, 7'h64);
        chk({sawStop, sawGo, brakeCyc == 0}, 3'b101, "probe off");
        $display("brake test done");
        report_and_stop();
    end
endmodule // tb
